/* File: conv_ctrl.sv */
// Converter control: Wishbone registers, bit-period timing, sleep and reset behaviour
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - converts in sleep only with RC clock
// - RC clock delays start one instruction cycle
// - done clears go, loads result
// - done sets flag with go clear
// - enabled done flag wakes from sleep
// - without enable, stays asleep, on kept
// - sleep with non-RC clock aborts conversion
// - reset restores registers, aborts conversion
// - reset leaves result register untouched
// - first code step at one LSb
// - write c1 gives RC, on, channel 0
// - interrupt control decodes in both banks
// - unimplemented bits ignore writes, read zero
// - go clear aborts, two-period wait follows
// - conversion lasts nine and half periods
// - select chooses 2, 8, 32 or RC
module conv_ctrl
    import conv_pkg::*;
#(
    parameter int width = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timing sources
    input wire logic rc_tick,
    // Analog samples per channel, scaled to code units
    input wire logic [4*width-1:0] analog_samples,
    // Sleep and interrupt
    input wire logic sleep_enter,
    output logic asleep,
    output logic wake,
    output logic irq,
    // Analog block power
    output logic converter_powered
);
    // ********************************************
    // Registers
    // ********************************************
    logic [7:0] converter_control_q; // Clock select, channel, go, on
    logic [7:0] peripheral_flags_q; // Done flag
    logic [7:0] peripheral_irq_enable_q; // Done enable
    logic [7:0] analog_pin_config_q; // Pin config field
    logic [7:0] pin_direction_q; // Pin directions
    logic [7:0] interrupt_control_q; // Global and peripheral enables
    logic [7:0] io_port_data_q; // Port latch
    logic [width-1:0] conversion_result_q; // Result, untouched by reset
    logic asleep_q; // Device sleeping
    conv_state_type state_q; // Converter state
    logic [5:0] div_q; // Oscillator divider
    logic [4:0] half_q; // Half bit-period counter
    logic half_tick; // One half bit period has passed
    logic [2:0] instr_q; // Instruction-cycle delay counter
    logic [7:0] reg_idx; // Word index from the byte address
    logic wr_stb; // Accepted write, one cycle
    logic [7:0] wr_byte; // Low byte of write data
    logic [1:0] clk_sel; // Current clock select
    logic go; // Go flag
    logic conv_on; // Converter on
    logic rc_mode; // RC clock selected
    logic done_evt; // Conversion complete, one cycle
    logic sar_start; // Start pulse to the core
    logic [width-1:0] sar_code; // Core result
    logic [width-1:0] chan_sample; // Selected channel sample
    logic sleep_abort; // Sleep stopping a clock-derived conversion
    logic [5:0] div_limit; // Divider terminal count
    logic prev_half_q; // RC tick delayed one mclk, second half tick

    assign reg_idx = adr_i[9:2];
    // Writes land on the edge at which the master samples ack, never before it
    assign wr_stb = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign wr_byte = dat_i[7:0];
    assign clk_sel = converter_control_q[conv_clock_select_lsb +: 2];
    assign go = converter_control_q[go_bit];
    assign conv_on = converter_control_q[converter_on_bit];
    assign rc_mode = (clk_sel == clock_rc_code);
    assign chan_sample = analog_samples[converter_control_q[channel_select_lsb +: 2]*width +: width];
    // Abort with non-RC clock once asleep; the on bit still reads set
    assign sleep_abort = asleep_q && !rc_mode;
    // Analog block held off in sleep unless RC clocked
    assign converter_powered = conv_on && !sleep_abort;
    assign asleep = asleep_q;

    // ********************************************
    // Bit-period timing
    // ********************************************
    // Divider per clock select; RC ticks arrive on their own input
    always_comb begin
        case (clk_sel)
            2'b00: div_limit = 6'(osc_div_0 / 2 - 1);
            2'b01: div_limit = 6'(osc_div_1 / 2 - 1);
            2'b10: div_limit = 6'(osc_div_2 / 2 - 1);
            default: div_limit = 6'h00;
        endcase
    end

    // Half bit periods let the 9.5-period conversion count exactly
    always_ff @(posedge mclk) begin
        if (reset || state_q == st_idle) begin
            div_q <= 6'h00;
        end else if (!rc_mode) begin
            div_q <= (div_q >= div_limit) ? 6'h00 : div_q + 6'h01;
        end
    end
    // RC source gives full periods: count each as two halves with a one-mclk delayed copy of the tick
    always_ff @(posedge mclk) begin
        if (reset) begin
            prev_half_q <= 1'b0;
        end else begin
            // Second half of the RC period falls one mclk after the tick
            prev_half_q <= rc_mode && rc_tick;
        end
    end
    assign half_tick = rc_mode ? (rc_tick || prev_half_q) : (div_q >= div_limit);

    // ********************************************
    // Converter sequence
    // ********************************************
    // Idle -> (RC delay) -> convert -> wait 2 periods -> idle
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= st_idle;
            half_q <= 5'h00;
            instr_q <= 3'h0;
        end else begin
            case (state_q)
                st_idle: begin
                    half_q <= 5'h00;
                    instr_q <= 3'h0;
                    // Go with converter off starts nothing
                    if (go && conv_on && !sleep_abort) begin
                        state_q <= rc_mode ? st_delay : st_convert;
                    end
                end
                st_delay: begin
                    // One instruction cycle so the sleep instruction runs first
                    instr_q <= instr_q + 3'h1;
                    if (!go || !conv_on) begin
                        state_q <= st_idle;
                    end else if (instr_q == 3'(instr_cycles - 1)) begin
                        state_q <= st_convert;
                    end
                end
                st_convert: begin
                    if (!go || !conv_on || sleep_abort) begin
                        // Abort: result kept; 2-period pause then acquisition after go or on clears, no pause after a sleep abort
                        state_q <= st_wait;
                        half_q <= 5'h00;
                    end else if (half_tick) begin
                        if (half_q == 5'(conv_half_periods - 1)) begin
                            state_q <= st_wait;
                            half_q <= 5'h00;
                        end else begin
                            half_q <= half_q + 5'h01;
                        end
                    end
                end
                st_wait: begin
                    if (half_tick || sleep_abort) begin
                        if (half_q == 5'(abort_half_periods - 1) || sleep_abort) begin
                            state_q <= st_idle;
                        end else begin
                            half_q <= half_q + 5'h01;
                        end
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end
    assign sar_start = (state_q == st_idle || state_q == st_delay) && go && conv_on;
    // Completion on the last half period of a live conversion
    assign done_evt = (state_q == st_convert) && go && conv_on && !sleep_abort
        && half_tick && half_q == 5'(conv_half_periods - 1);

    conv_sar #(
        .width(width)
    ) conv_sar_inst (
        .mclk(mclk),
        .reset(reset),
        .start(sar_start),
        .step(half_tick && half_q[0] && state_q == st_convert),
        .sample(chan_sample),
        .code_q(sar_code)
    );

    // ********************************************
    // Register writes
    // ********************************************
    // Control: hardware clears go at completion; done beats a write
    always_ff @(posedge mclk) begin
        if (reset) begin
            converter_control_q <= converter_control_reset;
        end else begin
            if (wr_stb && reg_idx == converter_control_idx) begin
                converter_control_q <= wr_byte & converter_control_mask;
            end
            if (done_evt) begin
                converter_control_q[go_bit] <= 1'b0;
            end
        end
    end
    // Done flag: set wins over a software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            peripheral_flags_q <= peripheral_flags_reset;
        end else if (done_evt) begin
            peripheral_flags_q[conversion_done_bit] <= 1'b1;
        end else if (wr_stb && reg_idx == peripheral_flags_idx) begin
            peripheral_flags_q <= wr_byte & peripheral_bit_mask;
        end
    end
    // Enables, pin configuration and port
    always_ff @(posedge mclk) begin
        if (reset) begin
            peripheral_irq_enable_q <= peripheral_irq_enable_reset;
            analog_pin_config_q <= analog_pin_config_reset;
            pin_direction_q <= pin_direction_reset;
            interrupt_control_q <= interrupt_control_reset;
            io_port_data_q <= io_port_data_reset;
        end else if (wr_stb) begin
            case (reg_idx)
                peripheral_irq_enable_idx: peripheral_irq_enable_q <= wr_byte & peripheral_bit_mask;
                analog_pin_config_idx: analog_pin_config_q <= wr_byte & analog_pin_config_mask;
                pin_direction_idx: pin_direction_q <= wr_byte & pin_direction_mask;
                // Same storage from either bank
                interrupt_control_idx, interrupt_control_alt_idx: begin
                    interrupt_control_q <= wr_byte;
                end
                io_port_data_idx: io_port_data_q <= wr_byte;
                default: ;
            endcase
        end
    end
    // Result: no reset branch, so any reset leaves it as it was
    always_ff @(posedge mclk) begin
        if (done_evt) begin
            conversion_result_q <= sar_code;
        end else if (wr_stb && reg_idx == conversion_result_idx) begin
            conversion_result_q <= wr_byte[width-1:0];
        end
    end

    // ********************************************
    // Sleep and interrupt
    // ********************************************
    // Enabled completion wakes; otherwise sleep goes on
    assign wake = asleep_q && peripheral_flags_q[conversion_done_bit]
        && peripheral_irq_enable_q[conversion_done_bit];
    always_ff @(posedge mclk) begin
        if (reset) begin
            asleep_q <= 1'b0;
        end else if (wake) begin
            asleep_q <= 1'b0;
        end else if (sleep_enter) begin
            asleep_q <= 1'b1;
        end
    end
    assign irq = peripheral_flags_q[conversion_done_bit]
        && peripheral_irq_enable_q[conversion_done_bit]
        && interrupt_control_q[peripheral_irq_enable_pos]
        && interrupt_control_q[global_irq_enable_bit];

    // ********************************************
    // Wishbone answer: ack one cycle after request
    // ********************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= 32'h0000_0000;
            if (cyc_i && stb_i && !we_i && !ack_o) begin
                case (reg_idx)
                    converter_control_idx: dat_o[7:0] <= converter_control_q;
                    peripheral_flags_idx: dat_o[7:0] <= peripheral_flags_q;
                    peripheral_irq_enable_idx: dat_o[7:0] <= peripheral_irq_enable_q;
                    analog_pin_config_idx: dat_o[7:0] <= analog_pin_config_q;
                    pin_direction_idx: dat_o[7:0] <= pin_direction_q;
                    interrupt_control_idx, interrupt_control_alt_idx: begin
                        dat_o[7:0] <= interrupt_control_q;
                    end
                    io_port_data_idx: dat_o[7:0] <= io_port_data_q;
                    conversion_result_idx: dat_o[width-1:0] <= conversion_result_q;
                    sleep_control_idx: dat_o[0] <= asleep_q;
                    // Unmapped reads as zero
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* File: conv_pkg.sv */
// Package: register map, field positions, reset values and timing of the converter control
package conv_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] io_port_data_idx = 8'h05;
    localparam logic [7:0] interrupt_control_idx = 8'h0b;
    localparam logic [7:0] interrupt_control_alt_idx = 8'h8b;
    localparam logic [7:0] peripheral_flags_idx = 8'h0c;
    localparam logic [7:0] conversion_result_idx = 8'h1e;
    localparam logic [7:0] converter_control_idx = 8'h1f;
    localparam logic [7:0] pin_direction_idx = 8'h85;
    localparam logic [7:0] peripheral_irq_enable_idx = 8'h8c;
    localparam logic [7:0] analog_pin_config_idx = 8'h9f;
    localparam logic [7:0] sleep_control_idx = 8'hf0;
    // Field positions
    localparam int conv_clock_select_lsb = 6;
    localparam int channel_select_lsb = 3;
    localparam int go_bit = 2;
    localparam int converter_on_bit = 0;
    localparam int conversion_done_bit = 6;
    localparam int global_irq_enable_bit = 7;
    localparam int peripheral_irq_enable_pos = 6;
    // Writable masks; other bits read as zero
    localparam logic [7:0] converter_control_mask = 8'hdd;
    localparam logic [7:0] peripheral_bit_mask = 8'h40;
    localparam logic [7:0] analog_pin_config_mask = 8'h07;
    localparam logic [7:0] pin_direction_mask = 8'h3f;
    // Reset values
    localparam logic [7:0] converter_control_reset = 8'h00;
    localparam logic [7:0] peripheral_flags_reset = 8'h00;
    localparam logic [7:0] peripheral_irq_enable_reset = 8'h00;
    localparam logic [7:0] analog_pin_config_reset = 8'h00;
    localparam logic [7:0] pin_direction_reset = 8'h3f;
    localparam logic [7:0] interrupt_control_reset = 8'h00;
    localparam logic [7:0] io_port_data_reset = 8'h00;
    // Clock select codes
    localparam logic [1:0] clock_rc_code = 2'h3;
    // Bit-period dividers in oscillator periods for codes 00, 01, 10
    localparam int osc_div_0 = 2;
    localparam int osc_div_1 = 8;
    localparam int osc_div_2 = 32;
    // Half bit periods: 9.5 bit periods per conversion, 2 bit periods abort wait
    localparam int conv_half_periods = 19;
    localparam int abort_half_periods = 4;
    // Mclk cycles per instruction cycle (start delay under the RC clock)
    localparam int instr_cycles = 4;
    // Converter states
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_delay = 2'b01,
        st_convert = 2'b10,
        st_wait = 2'b11
    } conv_state_type;
endpackage

/* File: conv_sar.sv */
// Successive-approximation core: uniform 8-bit quantiser stepped once per bit period
`timescale 1ns/100ps
module conv_sar
    import conv_pkg::*;
#(
    parameter int width = 8
) (
    // Clock and control
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    input wire logic step,
    // Analog sample, scaled so that full reference equals 2**width
    input wire logic [width-1:0] sample,
    // Result
    output logic [width-1:0] code_q
);
    logic [width-1:0] trial_q; // Bit currently under test
    logic [width-1:0] held_q; // Sample held at start

    // ********************************************
    // Bitwise compare; one LSb is reference/256
    // ********************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            trial_q <= '0;
            code_q <= '0;
            held_q <= '0;
        end else if (start) begin
            held_q <= sample;
            code_q <= '0;
            trial_q <= {1'b1, {(width-1){1'b0}}};
        end else if (step && trial_q != '0) begin
            // Keep the trial bit when the input reaches it: uniform steps, first at 1 LSb
            if (held_q >= (code_q | trial_q)) begin
                code_q <= code_q | trial_q;
            end
            trial_q <= trial_q >> 1;
        end
    end
endmodule

/* File: conv_ctrl_monitor.sv */
// Checker: port-level timing and flag relations of the converter control
`timescale 1ns/100ps
module conv_ctrl_monitor
    import conv_pkg::*;
#(
    parameter int width = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Wishbone slave side
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Timing and samples
    input wire logic rc_tick,
    input wire logic [4*width-1:0] analog_samples,
    // Sleep and interrupt
    input wire logic sleep_enter,
    input wire logic asleep,
    input wire logic wake,
    input wire logic irq,
    input wire logic converter_powered
);
    // ****************************************
    // Helper logic
    // ****************************************
    logic req_q; // A request stood in the previous cycle
    logic rd_unmapped_q; // Previous cycle held a read of an unmapped word
    // Remember the request so that ack can be tied to its cause
    always_ff @(posedge mclk) begin
        req_q <= cyc_i && stb_i;
        rd_unmapped_q <= cyc_i && stb_i && !we_i && (adr_i[9:2] == 8'h40);
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");
    property p_ack_reply; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_reply: assert property (p_ack_reply) else $error("no ack");
    property p_ack_cause; $rose(ack_o) |-> req_q; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_reset_quiet; $past(reset) |-> !ack_o && !asleep && !irq; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset state");
    property p_upper_zero; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper data");
    property p_unmapped; ack_o && rd_unmapped_q |-> dat_o == 32'h00000000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_wake_asleep; wake |-> asleep; endproperty
    a_wake_asleep: assert property (p_wake_asleep) else $error("wake awake");
    property p_irq_wakes; irq && asleep |-> wake; endproperty
    a_irq_wakes: assert property (p_irq_wakes) else $error("no wake");
    property p_sleep_cause; $rose(asleep) |-> $past(sleep_enter); endproperty
    a_sleep_cause: assert property (p_sleep_cause) else $error("stray sleep");
    // Main scenarios reached
    c_wake: cover property (wake);
    c_irq: cover property (irq);
    c_power_cut: cover property (asleep && !converter_powered);
endmodule
bind conv_ctrl conv_ctrl_monitor #(.width(width)) conv_ctrl_monitor_inst (.mclk(mclk),
    .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rc_tick(rc_tick),
    .analog_samples(analog_samples), .sleep_enter(sleep_enter), .asleep(asleep),
    .wake(wake), .irq(irq), .converter_powered(converter_powered));

/* File: conv_far_side.sv */
// Far side model: internal RC oscillator and analog input pins
`timescale 1ns/100ps
module conv_far_side #(
    parameter int rc_div = 10
) (
    // Clock
    input wire logic mclk,
    // RC bit-period pulse
    output logic rc_tick,
    // Channel samples in code units
    output logic [31:0] analog_samples
);
    int n = 0; // Oscillator phase
    // Oscillator runs free; shortened period keeps the run short
    always @(posedge mclk) begin
        n <= (n == rc_div - 1) ? 0 : n + 1;
        rc_tick <= (n == rc_div - 1);
    end
    // Channel 1 sits exactly at one LSb to probe the first step
    assign analog_samples = {8'hff, 8'h80, 8'h01, 8'h00};
endmodule

/* File: conv_ctrl_tb.sv */
// Testbench: registers, conversions, sleep and reset of the converter control
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module conv_ctrl_tb;
    import conv_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic mclk, reset = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, sleep_enter = 1'b0;
    logic [9:0] adr_i = 10'h000;
    logic [3:0] sel_i = 4'hf; // Byte lane 0 always enabled
    logic [31:0] dat_i = 32'h0, dat_o, analog_samples;
    logic ack_o, rc_tick, asleep, wake, irq, converter_powered;
    logic [7:0] rd;
    int err_count = 0, n_tests = 0, cnt = 0, t0, n;
    typedef struct {logic w; logic [7:0] wi, ri, wd, ex;} row_type;
    // Write flag, write index, read index, write data, expected read
    row_type rows[20] = '{'{0, 0, 8'h1f, 0, 8'h00}, '{0, 0, 8'h0c, 0, 8'h00},
        '{0, 0, 8'h8c, 0, 8'h00}, '{0, 0, 8'h9f, 0, 8'h00}, '{0, 0, 8'h85, 0, 8'h3f},
        '{0, 0, 8'h0b, 0, 8'h00}, '{0, 0, 8'hf0, 0, 8'h00}, '{1, 8'h9f, 8'h9f, 8'hff, 8'h07},
        '{1, 8'h85, 8'h85, 8'h0a, 8'h0a}, '{1, 8'h8c, 8'h8c, 8'hff, 8'h40},
        '{1, 8'h0b, 8'h8b, 8'hc0, 8'hc0}, '{1, 8'h8b, 8'h0b, 8'h40, 8'h40},
        '{1, 8'h40, 8'h40, 8'hff, 8'h00}, '{1, 8'h1e, 8'h1e, 8'h5a, 8'h5a},
        '{1, 8'h1f, 8'h1f, 8'hd9, 8'hd9}, '{1, 8'h0c, 8'h0c, 8'hff, 8'h40},
        '{1, 8'h1f, 8'h1f, 8'h00, 8'h00}, '{1, 8'h0c, 8'h0c, 8'h00, 8'h00},
        '{1, 8'h8c, 8'h8c, 8'h00, 8'h00}, '{1, 8'h0b, 8'h0b, 8'h00, 8'h00}};
    logic [7:0] samp[4] = '{8'h00, 8'h01, 8'h80, 8'hff}; // Codes the far side presents
    int divs[3] = '{2, 8, 32}; // Bit period in mclk per select code
    // ****************************************
    // Instances and clock
    // ****************************************
    conv_ctrl conv_ctrl_inst (.mclk(mclk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .rc_tick(rc_tick), .analog_samples(analog_samples),
        .sleep_enter(sleep_enter), .asleep(asleep), .wake(wake), .irq(irq),
        .converter_powered(converter_powered));
    conv_far_side conv_far_side_inst (.mclk(mclk), .rc_tick(rc_tick),
        .analog_samples(analog_samples));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) cnt <= cnt + 1;
    // ****************************************
    // Tasks
    // ****************************************
    // Classic single cycle; holds until ack is sampled, then idles one cycle
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h000000, wd};
        do begin
            @(posedge mclk);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50) err_count++;
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task do_reset;
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
    endtask
    task do_sleep;
        sleep_enter <= 1'b1;
        @(posedge mclk);
        sleep_enter <= 1'b0;
        @(posedge mclk);
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog sized well above the longest sequence
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        final_report;
    end
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        do_reset;
        foreach (rows[i]) begin
            if (rows[i].w) wb(1'b1, rows[i].wi, rows[i].wd);
            wb(1'b0, rows[i].ri, 8'h00);
            `CHK(rd, rows[i].ex)
        end
        $display("register table done");
        // Clock-derived conversions on channel c with select code c
        for (int c = 0; c < 3; c++) begin
            wb(1'b1, 8'h1f, {c[1:0], 1'b0, c[1:0], 3'b001});
            wb(1'b1, 8'h1f, {c[1:0], 1'b0, c[1:0], 3'b101});
            t0 = cnt;
            do wb(1'b0, 8'h1f, 8'h00); while (rd[2] === 1'b1 && cnt - t0 < 500);
            `CHK(cnt - t0 >= 19 * divs[c] / 2 - 2 && cnt - t0 <= 19 * divs[c] / 2 + 8, 1'b1)
            wb(1'b0, 8'h1e, 8'h00);
            `CHK(rd, samp[c])
            wb(1'b0, 8'h0c, 8'h00);
            `CHK(rd, 8'h40)
            wb(1'b1, 8'h0c, 8'h00);
            repeat (80) @(posedge mclk); // Two bit periods pass before the next go
        end
        $display("conversion timing done");
        // RC conversion through sleep with the done interrupt enabled
        do_reset;
        `CHK(asleep, 1'b0)
        wb(1'b1, 8'h8c, 8'h40);
        wb(1'b1, 8'h1f, 8'hc1);
        wb(1'b0, 8'h1f, 8'h00);
        `CHK(rd, 8'hc1)
        wb(1'b1, 8'h1f, 8'hd1);
        wb(1'b1, 8'h1f, 8'hd5);
        do_sleep;
        `CHK(asleep, 1'b1)
        n = 0;
        while (wake !== 1'b1 && n < 500) begin
            @(posedge mclk);
            n++;
        end
        `CHK(wake, 1'b1)
        `CHK(n >= 80, 1'b1)
        `CHK(n <= 110, 1'b1)
        `CHK(irq, 1'b0)
        wb(1'b0, 8'h1e, 8'h00);
        `CHK(rd, 8'h80)
        wb(1'b1, 8'h0b, 8'hc0);
        `CHK(irq, 1'b1)
        wb(1'b1, 8'h8c, 8'h00);
        `CHK(irq, 1'b0)
        $display("sleep wake done");
        // Sleep conversion with the interrupt left disabled
        do_reset;
        wb(1'b1, 8'h1f, 8'hc1);
        wb(1'b1, 8'h1f, 8'hc5);
        do_sleep;
        repeat (300) @(posedge mclk);
        `CHK(wake, 1'b0)
        `CHK(asleep, 1'b1)
        wb(1'b0, 8'h1f, 8'h00);
        `CHK(rd, 8'hc1)
        wb(1'b0, 8'h0c, 8'h00);
        `CHK(rd, 8'h40)
        $display("sleep stay done");
        // Clock-derived conversion cut off by sleep
        do_reset;
        wb(1'b1, 8'h1e, 8'ha5);
        wb(1'b1, 8'h1f, 8'h81);
        wb(1'b1, 8'h1f, 8'h85);
        `CHK(converter_powered, 1'b1)
        do_sleep;
        `CHK(converter_powered, 1'b0)
        wb(1'b0, 8'h1f, 8'h00);
        `CHK(rd[0], 1'b1)
        repeat (400) @(posedge mclk);
        wb(1'b0, 8'h0c, 8'h00);
        `CHK(rd, 8'h00)
        $display("sleep abort done");
        // Software abort, result kept across reset, go while off
        do_reset;
        wb(1'b1, 8'h1f, 8'h81);
        wb(1'b1, 8'h1f, 8'h85);
        repeat (20) @(posedge mclk);
        wb(1'b1, 8'h1f, 8'h81);
        repeat (400) @(posedge mclk);
        wb(1'b0, 8'h1e, 8'h00);
        `CHK(rd, 8'ha5)
        wb(1'b0, 8'h0c, 8'h00);
        `CHK(rd, 8'h00)
        wb(1'b1, 8'h1f, 8'h00);
        wb(1'b1, 8'h1f, 8'h04);
        repeat (400) @(posedge mclk);
        wb(1'b0, 8'h0c, 8'h00);
        `CHK(rd, 8'h00)
        $display("abort and off done");
        final_report;
    end
endmodule
